// ===== design/ppmc_regs.sv
// Operation
// - Capabilities bits 15:11 read constant 0x09: wake from D0 and D3hot.
// - Wake signal may be asserted only in D0 or D3hot.
// - Capabilities bit 10 reads zero: no D2 state.
// - Capabilities bit 9 reads zero: no D1 state.
// - Capabilities bit 5 reads zero: no device-specific initialization.
// - Capabilities bit 3 reads zero: wake needs no bus clock.
// - Capabilities bits 2:0 read 0x2, interface version 1.1.
// - Local wake trigger sets the wake-event pending flag, bit 15.
// - Host writes one to clear pending; writing zero does nothing.
// - Host clearing the pending flag raises a wake-cleared event flag.
// - Bit 8 is read-write wake enable, reset zero, gating wake.
// - Host setting wake enable sets the wake-enable-set status flag.
// - Host changing power state sets the power-state-changed flag.
// - Current power state mirrored to a local read-only output.
// - Power state codes: 00b D0, 11b D3hot; 01b and 10b reserved.
// - Power state resets to D0.
// - Host reaches registers only by config cycles, only in satellite mode.
// - Preceding capability entry has ID 0x01 and next pointer zero.
`timescale 1ns/1ps
`default_nettype none

module ppmc_regs
	import ppmc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        satellite_mode,
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output var  logic [31:0] cfg_rdata,
	output var  logic        cfg_ack,
	input  wire logic        wake_event_trigger,
	input  wire logic        clear_wake_enable_set,
	input  wire logic        clear_power_state_changed,
	input  wire logic        clear_wake_cleared,
	output var  logic        wake_enable_set_flag,
	output var  logic        power_state_changed_flag,
	output var  logic        wake_cleared_flag,
	output var  logic [1:0]  satellite_power_state_mirror,
	input  wire logic        wake_pin_i,
	output var  logic        wake_pin_o,
	output var  logic        wake_pin_oe,
	output var  logic        wake_line_low
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	logic        cfg_hit;
	logic        sel_cap;
	logic        sel_csr;
	logic        wr_csr;
	logic        pending_clear;
	logic        ps_write_ok;
	logic        ps_change;
	logic        enable_rise;
	logic        wake_clear_evt;
	logic        wake_event_pending;
	logic        wake_assert_enable;
	logic        next_wake_assert_enable;
	logic [1:0]  next_power_state;
	logic [15:0] power_capabilities;
	logic [15:0] power_control_status;
	logic [31:0] read_word;
	logic [31:0] next_cfg_rdata;
	logic        next_cfg_ack;
	logic        next_wake_pin_oe;
	logic        wake_line_level;

	always_comb begin
		cfg_hit = satellite_mode & (cfg_rd | cfg_wr);
		sel_cap = (cfg_addr[7:2] == CAP_DWORD_IDX);
		sel_csr = (cfg_addr[7:2] == CSR_DWORD_IDX);
		wr_csr  = satellite_mode & cfg_wr & sel_csr;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fixed capability word

	always_comb begin
		power_capabilities               = 16'h0000;
		power_capabilities[15:11]        = WAKE_SOURCE_STATES;
		power_capabilities[10]           = STATE_TWO_CAPABLE;
		power_capabilities[9]            = STATE_ONE_CAPABLE;
		power_capabilities[5]            = DEV_SPECIFIC_INIT;
		power_capabilities[3]            = WAKE_NEEDS_BUS_CLOCK;
		power_capabilities[2:0]          = PM_INTERFACE_VERSION;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control/status word

	always_comb begin
		pending_clear = wr_csr & cfg_be[CSR_HIGH_LANE] & cfg_wdata[WAKE_PENDING_BIT];
		wake_clear_evt = pending_clear & wake_event_pending;

		next_wake_assert_enable = wake_assert_enable;
		if (wr_csr && cfg_be[CSR_HIGH_LANE]) begin
			next_wake_assert_enable = cfg_wdata[WAKE_ENABLE_BIT];
		end
		enable_rise = next_wake_assert_enable & ~wake_assert_enable;

		// Reserved codes are dropped so the field only ever holds a supported state
		ps_write_ok = wr_csr & cfg_be[CSR_LOW_LANE]
			& ((cfg_wdata[PSTATE_LSB +: 2] == PPMC_D0) | (cfg_wdata[PSTATE_LSB +: 2] == PPMC_D3HOT));
		next_power_state = satellite_power_state_mirror;
		if (ps_write_ok) begin
			next_power_state = cfg_wdata[PSTATE_LSB +: 2];
		end
		ps_change = ps_write_ok & (cfg_wdata[PSTATE_LSB +: 2] != satellite_power_state_mirror);

		power_control_status                      = 16'h0000;
		power_control_status[WAKE_PENDING_BIT]    = wake_event_pending;
		power_control_status[WAKE_ENABLE_BIT]     = wake_assert_enable;
		power_control_status[PSTATE_LSB +: 2]     = satellite_power_state_mirror;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wake_assert_enable           <= WAKE_ENABLE_RESET;
			satellite_power_state_mirror <= PSTATE_RESET;
		end else begin
			wake_assert_enable           <= next_wake_assert_enable;
			satellite_power_state_mirror <= next_power_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky flags

	ppmc_flag u_wake_pending (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.set_pulse (wake_event_trigger),
		.clr_pulse (pending_clear),
		.q         (wake_event_pending)
	);

	ppmc_flag u_enable_set (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.set_pulse (enable_rise),
		.clr_pulse (clear_wake_enable_set),
		.q         (wake_enable_set_flag)
	);

	ppmc_flag u_state_changed (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.set_pulse (ps_change),
		.clr_pulse (clear_power_state_changed),
		.q         (power_state_changed_flag)
	);

	ppmc_flag u_wake_cleared (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.set_pulse (wake_clear_evt),
		.clr_pulse (clear_wake_cleared),
		.q         (wake_cleared_flag)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration read path

	always_comb begin
		read_word = READ_IDLE_VALUE;
		if (sel_cap) begin
			read_word = {power_capabilities, NEXT_ITEM_VALUE, CAP_ID_VALUE};
		end else if (sel_csr) begin
			read_word = {16'h0000, power_control_status};
		end
		next_cfg_rdata = READ_IDLE_VALUE;
		if (cfg_hit && cfg_rd) begin
			next_cfg_rdata = read_word;
		end
		next_cfg_ack = cfg_hit;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_rdata <= READ_IDLE_VALUE;
			cfg_ack   <= 1'b0;
		end else begin
			cfg_rdata <= next_cfg_rdata;
			cfg_ack   <= next_cfg_ack;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wake pin (open drain, active low)

	always_comb begin
		next_wake_pin_oe = wake_event_pending & wake_assert_enable
			& ((satellite_power_state_mirror == PPMC_D0) | (satellite_power_state_mirror == PPMC_D3HOT));
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wake_pin_oe   <= 1'b0;
			wake_pin_o    <= 1'b0;
			wake_line_low <= 1'b0;
		end else begin
			wake_pin_oe   <= next_wake_pin_oe;
			// Open drain: only ever pulls low, the pull-up gives the idle level
			wake_pin_o    <= 1'b0;
			wake_line_low <= ~wake_line_level;
		end
	end

	// Shared line; another agent may hold it low too
	ppmc_sync3 #(
		.RESET_LEVEL (1'b1)
	) u_wake_sync (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (wake_pin_i),
		.level    (wake_line_level)
	);

endmodule : ppmc_regs

`default_nettype wire

// ===== design/ppmc_pkg.sv
package ppmc_pkg;

	// Configuration space placement (byte offsets)
	localparam logic [7:0]  CAP_ID_OFFSET          = 8'hdc;
	localparam logic [7:0]  POWER_CAPABILITIES_OFF = 8'hde;
	localparam logic [7:0]  POWER_CTRL_STATUS_OFF  = 8'he0;
	localparam logic [5:0]  CAP_DWORD_IDX          = CAP_ID_OFFSET[7:2];
	localparam logic [5:0]  CSR_DWORD_IDX          = POWER_CTRL_STATUS_OFF[7:2];

	// Capability list entry
	localparam logic [7:0]  CAP_ID_VALUE           = 8'h01;
	localparam logic [7:0]  NEXT_ITEM_VALUE        = 8'h00;

	// power_capabilities fields
	localparam logic [4:0]  WAKE_SOURCE_STATES     = 5'h09;
	localparam logic        STATE_TWO_CAPABLE      = 1'h0;
	localparam logic        STATE_ONE_CAPABLE      = 1'h0;
	localparam logic        DEV_SPECIFIC_INIT      = 1'h0;
	localparam logic        WAKE_NEEDS_BUS_CLOCK   = 1'h0;
	localparam logic [2:0]  PM_INTERFACE_VERSION   = 3'h2;

	// power_control_status field positions
	localparam int          WAKE_PENDING_BIT       = 15;
	localparam int          WAKE_ENABLE_BIT        = 8;
	localparam int          PSTATE_LSB             = 0;

	// Byte lanes holding the writable fields
	localparam int          CSR_HIGH_LANE          = 1;
	localparam int          CSR_LOW_LANE           = 0;

	// Reset values
	localparam logic        WAKE_ENABLE_RESET      = 1'h0;
	localparam logic [31:0] READ_IDLE_VALUE        = 32'h0000_0000;

	typedef enum logic [1:0] {
		PPMC_D0      = 2'b00,
		PPMC_D1_RSVD = 2'b01,
		PPMC_D2_RSVD = 2'b10,
		PPMC_D3HOT   = 2'b11
	} ppmc_pstate_e;

	localparam ppmc_pstate_e PSTATE_RESET = PPMC_D0;

endpackage : ppmc_pkg

// ===== design/ppmc_flag.sv
`timescale 1ns/1ps
`default_nettype none

// Sticky flag; a set in the same cycle as a clear wins
module ppmc_flag (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic set_pulse,
	input  wire logic clr_pulse,
	output var  logic q
);

	logic next_q;

	always_comb begin
		next_q = q;
		if (clr_pulse) begin
			next_q = 1'b0;
		end
		if (set_pulse) begin
			next_q = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

endmodule : ppmc_flag

`default_nettype wire

// ===== design/ppmc_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage input synchroniser; output moves only when stages two and three agree
module ppmc_sync3 #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic async_in,
	output var  logic level
);

	logic meta;
	logic stage2;
	logic stage3;
	logic next_level;

	always_comb begin
		next_level = level;
		if (stage2 == stage3) begin
			next_level = stage3;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta   <= RESET_LEVEL;
			stage2 <= RESET_LEVEL;
			stage3 <= RESET_LEVEL;
			level  <= RESET_LEVEL;
		end else begin
			meta   <= async_in;
			stage2 <= meta;
			stage3 <= stage2;
			level  <= next_level;
		end
	end

endmodule : ppmc_sync3

`default_nettype wire

// ===== tb/ppmc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ppmc_regs_monitor (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        satellite_mode,
	input wire logic        cfg_rd,
	input wire logic        cfg_wr,
	input wire logic [7:0]  cfg_addr,
	input wire logic [3:0]  cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_ack,
	input wire logic        clear_wake_cleared,
	input wire logic        wake_enable_set_flag,
	input wire logic        power_state_changed_flag,
	input wire logic        wake_cleared_flag,
	input wire logic [1:0]  satellite_power_state_mirror
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_ack_follows_req: assert property ((cfg_rd || cfg_wr) && satellite_mode |=> cfg_ack)
		else $error("request without ack");
	a_no_stray_ack: assert property (!(satellite_mode && (cfg_rd || cfg_wr)) |=> !cfg_ack)
		else $error("ack without accepted request");
	a_idle_rdata: assert property (!cfg_ack |-> cfg_rdata == 32'h0)
		else $error("read data outside ack");
	a_cap_word: assert property (satellite_mode && cfg_rd && cfg_addr[7:2] == 6'h37
		|=> cfg_rdata == 32'h4802_0001) else $error("capability dword wrong");
	a_mirror_legal: assert property (!(satellite_power_state_mirror inside {2'h1, 2'h2}))
		else $error("reserved power state held");
	a_state_write: assert property (satellite_mode && cfg_wr && cfg_addr[7:2] == 6'h38 && cfg_be[0]
		&& cfg_wdata[1:0] == 2'h3 |=> satellite_power_state_mirror == 2'h3) else $error("state write lost");
	a_state_flag: assert property (!$past(sys_rst) && $changed(satellite_power_state_mirror)
		|-> power_state_changed_flag) else $error("state change not flagged");
	a_enable_flag: assert property ($rose(wake_enable_set_flag)
		|-> $past(satellite_mode && cfg_wr && cfg_be[1] && cfg_wdata[8])) else $error("enable flag unprompted");
	a_cleared_flag: assert property ($rose(wake_cleared_flag) |-> $past(satellite_mode && cfg_wr
		&& cfg_addr[7:2] == 6'h38 && cfg_be[1] && cfg_wdata[15])) else $error("cleared flag unprompted");
	a_cleared_clr: assert property (clear_wake_cleared && !cfg_wr |=> !wake_cleared_flag)
		else $error("cleared flag stuck");
endmodule : ppmc_regs_monitor
bind ppmc_regs ppmc_regs_monitor u_mon (.sys_clk, .sys_rst, .satellite_mode, .cfg_rd, .cfg_wr, .cfg_addr,
	.cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .clear_wake_cleared, .wake_enable_set_flag,
	.power_state_changed_flag, .wake_cleared_flag, .satellite_power_state_mirror);
`default_nettype wire

// ===== tb/ppmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppmc_host_model (
	input  wire logic        sys_clk,
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_ack,
	input  wire logic        wake_pin_oe,
	output var  logic        cfg_rd,
	output var  logic        cfg_wr,
	output var  logic [7:0]  cfg_addr,
	output var  logic [3:0]  cfg_be,
	output var  logic [31:0] cfg_wdata,
	output var  logic        wake_pin_i
);
	// Pulled-up wake line, only the device pulls it low
	assign wake_pin_i = wake_pin_oe ? 1'b0 : 1'b1;
	initial begin
		cfg_rd = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end
	// One config cycle; answer taken while the ack cycle is settled
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
		output logic ack, output logic [31:0] rd);
		@(negedge sys_clk);
		cfg_rd = !wr;
		cfg_wr = wr;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		@(negedge sys_clk);
		ack = cfg_ack;
		rd = cfg_rdata;
		cfg_rd = 1'b0;
		cfg_wr = 1'b0;
		// Released bus shows garbage, not the last value
		cfg_addr = ~a;
		cfg_wdata = ~d;
	endtask : xfer
endmodule : ppmc_host_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        sys_clk, sys_rst, satellite_mode, trig, clr_es, clr_pc, clr_wc;
	logic        cfg_rd, cfg_wr, cfg_ack, es_flag, pc_flag, wc_flag, pin_i, pin_o, pin_oe, line_low;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [1:0]  mirror;
	int          miscompares, compares;
	ppmc_regs DUT (.sys_clk, .sys_rst, .satellite_mode, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
		.cfg_rdata, .cfg_ack, .wake_event_trigger(trig), .clear_wake_enable_set(clr_es),
		.clear_power_state_changed(clr_pc), .clear_wake_cleared(clr_wc), .wake_enable_set_flag(es_flag),
		.power_state_changed_flag(pc_flag), .wake_cleared_flag(wc_flag), .satellite_power_state_mirror(mirror),
		.wake_pin_i(pin_i), .wake_pin_o(pin_o), .wake_pin_oe(pin_oe), .wake_line_low(line_low));
	ppmc_host_model host (.sys_clk, .cfg_rdata, .cfg_ack, .wake_pin_oe(pin_oe), .cfg_rd, .cfg_wr, .cfg_addr,
		.cfg_be, .cfg_wdata, .wake_pin_i(pin_i));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chb
	task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
		input logic ack_exp, input logic [31:0] rd_exp);
		logic        ack;
		logic [31:0] rd;
		host.xfer(wr, a, be, d, ack, rd);
		chb(ack, ack_exp);
		if (!wr)
			chk(rd, rd_exp);
	endtask : acc
	task automatic pulse(input int which);
		@(negedge sys_clk);
		{trig, clr_es, clr_pc, clr_wc} = 4'h8 >> which;
		@(negedge sys_clk);
		{trig, clr_es, clr_pc, clr_wc} = 4'h0;
	endtask : pulse
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		acc(0, 8'hdc, 4'hf, 0, 1, 32'h4802_0001);
		acc(1, 8'hdc, 4'hf, 32'hffff_ffff, 1, 0);
		acc(0, 8'hdc, 4'hf, 0, 1, 32'h4802_0001);
		acc(0, 8'he0, 4'hf, 0, 1, 32'h0);
		acc(1, 8'he0, 4'hf, 32'hffff_7efc, 1, 0);
		acc(0, 8'he0, 4'hf, 0, 1, 32'h0);
		acc(0, 8'he4, 4'hf, 0, 1, 32'h0);
	endtask : t_regs
	task automatic t_pstate;
		acc(1, 8'he0, 4'h1, 32'h3, 1, 0);
		chk(mirror, 2'h3);
		chb(pc_flag, 1);
		pulse(2);
		chb(pc_flag, 0);
		for (int c = 1; c < 3; c++) begin
			acc(1, 8'he0, 4'h1, c, 1, 0);
			acc(0, 8'he0, 4'hf, 0, 1, 32'h3);
		end
		chb(pc_flag, 0);
		acc(1, 8'he0, 4'h1, 32'h0, 1, 0);
		chb(pc_flag, 1);
		chk(mirror, 2'h0);
		pulse(2);
	endtask : t_pstate
	task automatic t_wake;
		pulse(0);
		acc(0, 8'he0, 4'hf, 0, 1, 32'h8000);
		chb(pin_oe, 0);
		acc(1, 8'he0, 4'h2, 32'h100, 1, 0);
		chb(es_flag, 1);
		@(negedge sys_clk);
		chb(pin_oe, 1);
		chb(pin_o, 0);
		repeat (5) @(negedge sys_clk);
		chb(line_low, 1);
		pulse(1);
		chb(es_flag, 0);
		acc(1, 8'he0, 4'h2, 32'h100, 1, 0);
		acc(0, 8'he0, 4'hf, 0, 1, 32'h8100);
		acc(1, 8'he0, 4'h2, 32'h8100, 1, 0);
		chb(wc_flag, 1);
		@(negedge sys_clk);
		chb(pin_oe, 0);
		acc(0, 8'he0, 4'hf, 0, 1, 32'h0100);
		pulse(3);
		chb(wc_flag, 0);
	endtask : t_wake
	task automatic t_sat;
		satellite_mode = 1'b0;
		acc(1, 8'he0, 4'h3, 32'h3, 0, 0);
		acc(0, 8'he0, 4'hf, 0, 0, 32'h0);
		chk(mirror, 2'h0);
		satellite_mode = 1'b1;
	endtask : t_sat
	////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		satellite_mode = 1'b1;
		{trig, clr_es, clr_pc, clr_wc} = 4'h0;
		miscompares = 0;
		compares = 0;
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_regs;
		t_pstate;
		t_wake;
		t_sat;
		stop_test;
	end
	// About 75 cycles of work; generous margin
	initial begin
		#20000;
		miscompares++;
		stop_test;
	end
endmodule : tb
`default_nettype wire
